// File: hdl/dtc_pkg.sv
// Overview of operation
// - timer1 overflow sets bit 7 flag; timer0 split: timer0 high byte sets it instead
// - vectoring to timer1 routine clears that flag
// - bit 6 runs timer1; counts only when set
// - timer0 overflow sets bit 5 flag
// - vectoring to timer0 routine clears that flag
// - bit 4 runs timer0 (split: low byte only); counts only when set
// - ext irq1 falling edge or low sets bit 3
// - edge flags clear on vectoring; level flags follow pin
// - bit 2: one selects edge, zero selects level
// - ext irq0 falling edge or low sets bit 1
// - bit 0: one selects edge, zero selects level
// - irq bits never affect either timer
// - each timer two bytes, split or cascaded
// - timer0 bytes at 8c high, 8a low
// - timer1 bytes at 8d high, 8b low
// - mode field picks 13, 16, reload, split
// - gated run needs run bit and pin high
// - timer counts cycles; counter counts pin falls
// - reload mode refills low byte from high
package dtc_pkg;

    // special-function addresses
    localparam logic [7:0] ADDR_TCTL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_T0LO = 8'h8a;
    localparam logic [7:0] ADDR_T1LO = 8'h8b;
    localparam logic [7:0] ADDR_T0HI = 8'h8c;
    localparam logic [7:0] ADDR_T1HI = 8'h8d;

    // control register bits
    localparam int OVF1_BIT = 7;
    localparam int RUN1_BIT = 6;
    localparam int OVF0_BIT = 5;
    localparam int RUN0_BIT = 4;
    localparam int REQ1_BIT = 3;
    localparam int TRG1_BIT = 2;
    localparam int REQ0_BIT = 1;
    localparam int TRG0_BIT = 0;

    // mode register bits
    localparam int GATE1_BIT = 7;
    localparam int CT1_BIT   = 6;
    localparam int MODE1_LSB = 4;
    localparam int GATE0_BIT = 3;
    localparam int CT0_BIT   = 2;
    localparam int MODE0_LSB = 0;

    // mode codes
    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    // pin index into synchroniser
    localparam int PIN_IRQ0 = 0;
    localparam int PIN_IRQ1 = 1;
    localparam int PIN_CNT0 = 2;
    localparam int PIN_CNT1 = 3;
    localparam int NPINS    = 4;

    // reset values
    localparam logic [7:0] TCTL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CNT_RST  = 8'h00;
    localparam logic [2:0] SYNC_RST = 3'h7;
    localparam logic [7:0] RD_NONE  = 8'h00;

    typedef struct packed {
        logic [NPINS-1:0][2:0] sync;
        logic [NPINS-1:0]      flt;
        logic [7:0]            tctl;
        logic [7:0]            mode_reg;
        logic [7:0]            t0_lo;
        logic [7:0]            t0_hi;
        logic [7:0]            t1_lo;
        logic [7:0]            t1_hi;
        logic [7:0]            rdata;
        logic                  rvalid;
    } dtc_state_t;

    localparam dtc_state_t STATE_RST = '{
        sync:   {NPINS{SYNC_RST}},
        flt:    {NPINS{1'b1}},
        tctl:   TCTL_RST,
        mode_reg: MODE_RST,
        t0_lo:  CNT_RST,
        t0_hi:  CNT_RST,
        t1_lo:  CNT_RST,
        t1_hi:  CNT_RST,
        rdata:  RD_NONE,
        rvalid: 1'b0
    };

endpackage : dtc_pkg

// File: hdl/dtc_timer_ctl.sv
`timescale 1ns/10ps
module dtc_timer_ctl (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // special-function register port
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_RD,
    output logic      [7:0] SFR_RDATA,
    output logic            SFR_RVALID,
    // interrupt vectoring acknowledges
    input  wire logic       ACK_T0,
    input  wire logic       ACK_T1,
    input  wire logic       ACK_X0,
    input  wire logic       ACK_X1,
    // external pins
    input  wire logic       EXT_IRQ0_PIN_N,
    input  wire logic       EXT_IRQ1_PIN_N,
    input  wire logic       T0_COUNT_PIN,
    input  wire logic       T1_COUNT_PIN,
    // request flags to the core
    output logic            TIMER0_OVERFLOW_FLAG,
    output logic            TIMER1_OVERFLOW_FLAG,
    output logic            EXT_IRQ0_REQUEST_FLAG,
    output logic            EXT_IRQ1_REQUEST_FLAG
);
    import dtc_pkg::*;

    dtc_state_t r_ff;
    dtc_state_t nxt_r;

    logic [NPINS-1:0] pins;
    logic [NPINS-1:0] fall;
    logic [1:0]       mode0;
    logic [1:0]       mode1;
    logic             split0;
    logic             run0;
    logic             run1;
    logic             inc0;
    logic             inc1;
    logic [16:0]      step0;
    logic [16:0]      step1;
    logic             set_ovf0;
    logic             set_ovf1;
    logic             wr_tctl;
    logic             wr_t0;
    logic             wr_t1;

    // one count step: {overflow, high, low}
    function automatic logic [16:0] dtc_step(
        input logic [1:0] mode,
        input logic [7:0] tl,
        input logic [7:0] th,
        input logic       inc
    );
        logic [7:0] ntl;
        logic [7:0] nth;
        logic       ovf;
        ntl = tl;
        nth = th;
        ovf = 1'b0;
        if (inc) begin
            unique case (mode)
                MODE_13BIT: begin
                    // low five bits prescale the high byte
                    ntl[4:0] = tl[4:0] + 5'h01;
                    if (tl[4:0] == 5'h1f) begin
                        nth = th + 8'h01;
                        ovf = (th == 8'hff);
                    end
                end
                MODE_16BIT: begin
                    {nth, ntl} = {th, tl} + 16'h0001;
                    ovf = ({th, tl} == 16'hffff);
                end
                MODE_RELOAD: begin
                    if (tl == 8'hff) begin
                        ntl = th;
                        ovf = 1'b1;
                    end else begin
                        ntl = tl + 8'h01;
                    end
                end
                MODE_SPLIT: begin
                    ntl = tl + 8'h01;
                    ovf = (tl == 8'hff);
                end
            endcase
        end
        return {ovf, nth, ntl};
    endfunction : dtc_step

    assign pins = {T1_COUNT_PIN, T0_COUNT_PIN, EXT_IRQ1_PIN_N,
                   EXT_IRQ0_PIN_N};

    // falling edge on the filtered level
    for (genvar g = 0; g < NPINS; g++) begin : g_fall
        assign fall[g] = r_ff.flt[g] & ~r_ff.sync[g][1]
                       & ~r_ff.sync[g][2];
    end

    assign mode0  = r_ff.mode_reg[MODE0_LSB +: 2];
    assign mode1  = r_ff.mode_reg[MODE1_LSB +: 2];
    assign split0 = (mode0 == MODE_SPLIT);

    // run enables use only run, gate and pin; irq bits not involved
    assign run0 = r_ff.tctl[RUN0_BIT]
                & (~r_ff.mode_reg[GATE0_BIT]
                   | r_ff.flt[PIN_IRQ0]);
    assign run1 = r_ff.tctl[RUN1_BIT]
                & (~r_ff.mode_reg[GATE1_BIT]
                   | r_ff.flt[PIN_IRQ1]);
    assign inc0 = run0
                & (r_ff.mode_reg[CT0_BIT] ? fall[PIN_CNT0] : 1'b1);
    assign inc1 = run1
                & (r_ff.mode_reg[CT1_BIT] ? fall[PIN_CNT1] : 1'b1)
                & (mode1 != MODE_SPLIT);

    assign step0 = dtc_step(mode0, r_ff.t0_lo, r_ff.t0_hi, inc0);
    assign step1 = dtc_step(mode1, r_ff.t1_lo, r_ff.t1_hi, inc1);

    // in split mode the high byte of timer 0 owns timer 1's flag
    assign set_ovf0 = step0[16];
    assign set_ovf1 = split0 ? (r_ff.tctl[RUN1_BIT] & (r_ff.t0_hi == 8'hff))
                             : step1[16];

    assign wr_tctl = SFR_WR & (SFR_ADDR == ADDR_TCTL);
    assign wr_t0   = SFR_WR & ((SFR_ADDR == ADDR_T0LO)
                             | (SFR_ADDR == ADDR_T0HI));
    assign wr_t1   = SFR_WR & ((SFR_ADDR == ADDR_T1LO)
                             | (SFR_ADDR == ADDR_T1HI));

    always_comb begin
        nxt_r = r_ff;

        // three-stage synchroniser, level accepted when stages 2 and 3 agree
        for (int i = 0; i < NPINS; i++) begin
            nxt_r.sync[i] = {r_ff.sync[i][1:0], pins[i]};
            if (r_ff.sync[i][1] == r_ff.sync[i][2]) begin
                nxt_r.flt[i] = r_ff.sync[i][2];
            end
        end

        // counting
        nxt_r.t0_lo = step0[7:0];
        nxt_r.t0_hi = step0[15:8];
        if (split0) begin
            // high byte becomes a cycle timer run by timer 1's bit
            nxt_r.t0_hi = r_ff.tctl[RUN1_BIT] ? r_ff.t0_hi + 8'h01
                                              : r_ff.t0_hi;
        end
        nxt_r.t1_lo = step1[7:0];
        nxt_r.t1_hi = step1[15:8];

        // software writes to counters win over counting
        if (SFR_WR) begin
            unique case (SFR_ADDR)
                ADDR_T0LO: nxt_r.t0_lo    = SFR_WDATA;
                ADDR_T0HI: nxt_r.t0_hi    = SFR_WDATA;
                ADDR_T1LO: nxt_r.t1_lo    = SFR_WDATA;
                ADDR_T1HI: nxt_r.t1_hi    = SFR_WDATA;
                ADDR_MODE: nxt_r.mode_reg = SFR_WDATA;
                default: ;
            endcase
        end

        // flags: vectoring clear, then software write, then hardware set
        if (ACK_T0) begin
            nxt_r.tctl[OVF0_BIT] = 1'b0;
        end
        if (ACK_T1) begin
            nxt_r.tctl[OVF1_BIT] = 1'b0;
        end
        if (ACK_X0 & r_ff.tctl[TRG0_BIT]) begin
            nxt_r.tctl[REQ0_BIT] = 1'b0;
        end
        if (ACK_X1 & r_ff.tctl[TRG1_BIT]) begin
            nxt_r.tctl[REQ1_BIT] = 1'b0;
        end
        if (wr_tctl) begin
            nxt_r.tctl = SFR_WDATA;
        end
        nxt_r.tctl[OVF0_BIT] = nxt_r.tctl[OVF0_BIT]
                             | set_ovf0;
        nxt_r.tctl[OVF1_BIT] = nxt_r.tctl[OVF1_BIT]
                             | set_ovf1;
        if (nxt_r.tctl[TRG0_BIT]) begin
            nxt_r.tctl[REQ0_BIT] = nxt_r.tctl[REQ0_BIT]
                                 | fall[PIN_IRQ0];
        end else begin
            nxt_r.tctl[REQ0_BIT] = ~r_ff.flt[PIN_IRQ0];
        end
        if (nxt_r.tctl[TRG1_BIT]) begin
            nxt_r.tctl[REQ1_BIT] = nxt_r.tctl[REQ1_BIT]
                                 | fall[PIN_IRQ1];
        end else begin
            nxt_r.tctl[REQ1_BIT] = ~r_ff.flt[PIN_IRQ1];
        end

        // registered read, unmapped addresses read zero
        nxt_r.rvalid = SFR_RD;
        if (SFR_RD) begin
            unique case (SFR_ADDR)
                ADDR_TCTL: nxt_r.rdata = r_ff.tctl;
                ADDR_MODE: nxt_r.rdata = r_ff.mode_reg;
                ADDR_T0LO: nxt_r.rdata = r_ff.t0_lo;
                ADDR_T0HI: nxt_r.rdata = r_ff.t0_hi;
                ADDR_T1LO: nxt_r.rdata = r_ff.t1_lo;
                ADDR_T1HI: nxt_r.rdata = r_ff.t1_hi;
                default:   nxt_r.rdata = RD_NONE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            r_ff <= STATE_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign SFR_RDATA             = r_ff.rdata;
    assign SFR_RVALID            = r_ff.rvalid;
    assign TIMER0_OVERFLOW_FLAG  = r_ff.tctl[OVF0_BIT];
    assign TIMER1_OVERFLOW_FLAG  = r_ff.tctl[OVF1_BIT];
    assign EXT_IRQ0_REQUEST_FLAG = r_ff.tctl[REQ0_BIT];
    assign EXT_IRQ1_REQUEST_FLAG = r_ff.tctl[REQ1_BIT];

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_ovf1_set: assert property (
        set_ovf1 |=> TIMER1_OVERFLOW_FLAG)
        else $error("timer1 overflow did not set its flag");

    chk_ovf1_clear: assert property (
        ACK_T1 && !set_ovf1 && !wr_tctl |=> !TIMER1_OVERFLOW_FLAG)
        else $error("timer1 flag not cleared on vectoring");

    chk_t1_stopped: assert property (
        !r_ff.tctl[RUN1_BIT] && !wr_t1
        |=> $stable(r_ff.t1_lo) && $stable(r_ff.t1_hi))
        else $error("timer1 moved while stopped");

    chk_ovf0_set: assert property (
        set_ovf0 |=> TIMER0_OVERFLOW_FLAG)
        else $error("timer0 overflow did not set its flag");

    chk_ovf0_clear: assert property (
        ACK_T0 && !set_ovf0 && !wr_tctl |=> !TIMER0_OVERFLOW_FLAG)
        else $error("timer0 flag not cleared on vectoring");

    chk_t0_stopped: assert property (
        !r_ff.tctl[RUN0_BIT] && !wr_t0 |=> $stable(r_ff.t0_lo))
        else $error("timer0 low byte moved while stopped");

    chk_irq1_edge: assert property (
        r_ff.tctl[TRG1_BIT] && !wr_tctl
        && r_ff.flt[PIN_IRQ1] ##1 !r_ff.flt[PIN_IRQ1]
        |=> EXT_IRQ1_REQUEST_FLAG)
        else $error("irq1 falling edge missed");

    chk_irq0_level: assert property (
        !r_ff.tctl[TRG0_BIT] && !wr_tctl
        |=> EXT_IRQ0_REQUEST_FLAG == !$past(r_ff.flt[PIN_IRQ0]))
        else $error("irq0 level flag does not follow pin");

    chk_irq1_level: assert property (
        !r_ff.tctl[TRG1_BIT] && !wr_tctl
        |=> EXT_IRQ1_REQUEST_FLAG == !$past(r_ff.flt[PIN_IRQ1]))
        else $error("irq1 level flag does not follow pin");

    chk_irq0_edge: assert property (
        r_ff.tctl[TRG0_BIT] && !wr_tctl && fall[PIN_IRQ0]
        |=> EXT_IRQ0_REQUEST_FLAG)
        else $error("irq0 falling edge missed");

    chk_irq0_no_rise: assert property (
        r_ff.tctl[TRG0_BIT] && !wr_tctl && !fall[PIN_IRQ0]
        |=> !$rose(EXT_IRQ0_REQUEST_FLAG))
        else $error("irq0 edge flag rose without an edge");

    chk_t0_cascade: assert property (
        mode0 == MODE_16BIT && r_ff.tctl[RUN0_BIT] && !wr_t0
        && !r_ff.mode_reg[GATE0_BIT] && !r_ff.mode_reg[CT0_BIT]
        |=> {r_ff.t0_hi, r_ff.t0_lo}
            == $past({r_ff.t0_hi, r_ff.t0_lo}) + 16'h0001)
        else $error("timer0 cascaded count did not step");

    chk_t0_hi_write: assert property (
        SFR_WR && SFR_ADDR == ADDR_T0HI
        |=> r_ff.t0_hi == $past(SFR_WDATA))
        else $error("timer0 high byte write lost");

    chk_t0_lo_read: assert property (
        SFR_RD && SFR_ADDR == ADDR_T0LO
        |=> SFR_RVALID && SFR_RDATA == $past(r_ff.t0_lo))
        else $error("timer0 low byte read wrong");

    chk_t1_lo_write: assert property (
        SFR_WR && SFR_ADDR == ADDR_T1LO
        |=> r_ff.t1_lo == $past(SFR_WDATA))
        else $error("timer1 low byte write lost");

    chk_t1_split_hold: assert property (
        mode1 == MODE_SPLIT && !wr_t1
        |=> $stable(r_ff.t1_lo) && $stable(r_ff.t1_hi))
        else $error("timer1 moved in its hold mode");

    chk_gate_hold: assert property (
        r_ff.mode_reg[GATE0_BIT] && !r_ff.flt[PIN_IRQ0]
        && !split0 && !wr_t0
        |=> $stable(r_ff.t0_lo) && $stable(r_ff.t0_hi))
        else $error("gated timer0 counted with pin low");

    chk_timer_inc: assert property (
        mode0 == MODE_16BIT && run0 && !r_ff.mode_reg[CT0_BIT]
        && !wr_t0 && r_ff.t0_lo != 8'hff
        |=> r_ff.t0_lo == $past(r_ff.t0_lo) + 8'h01)
        else $error("timer0 did not count a machine cycle");

    chk_t1_cnt_edge: assert property (
        run1 && r_ff.mode_reg[CT1_BIT] && !fall[PIN_CNT1] && !wr_t1
        |=> $stable(r_ff.t1_lo) && $stable(r_ff.t1_hi))
        else $error("timer1 counter moved without a pin fall");

    chk_reload: assert property (
        mode0 == MODE_RELOAD && inc0 && r_ff.t0_lo == 8'hff && !wr_t0
        |=> r_ff.t0_lo == $past(r_ff.t0_hi) && TIMER0_OVERFLOW_FLAG)
        else $error("reload mode did not refill low byte");

    chk_flag_write: assert property (
        wr_tctl && !set_ovf0
        |=> TIMER0_OVERFLOW_FLAG == $past(SFR_WDATA[OVF0_BIT]))
        else $error("timer0 flag did not take the written value");

    chk_sync_filter: assert property (
        r_ff.sync[PIN_IRQ1][1] == r_ff.sync[PIN_IRQ1][2]
        |=> r_ff.flt[PIN_IRQ1] == $past(r_ff.sync[PIN_IRQ1][2]))
        else $error("irq1 filtered level missed agreeing samples");

    cov_ovf0_rise: cover property ($rose(TIMER0_OVERFLOW_FLAG));
    cov_irq1_edge: cover property (
        r_ff.tctl[TRG1_BIT] && fall[PIN_IRQ1]);
    cov_reload: cover property (
        mode0 == MODE_RELOAD && set_ovf0);
    cov_split_ovf1: cover property (split0 && set_ovf1);
    cov_irq0_level: cover property (
        !r_ff.tctl[TRG0_BIT] && EXT_IRQ0_REQUEST_FLAG);

endmodule : dtc_timer_ctl

// File: verif/dtc_pin_model.sv
`timescale 1ns/10ps
module dtc_pin_model (
    // clock
    input  wire logic       clk,
    // requests from the bench
    input  wire logic [1:0] irq_low,
    input  wire logic [7:0] pulses,
    input  wire logic       go,
    // pins toward the block
    output logic            irq0_n,
    output logic            irq1_n,
    output logic            cnt_pin,
    output logic            busy
);
    int left;

    initial begin
        left    = 0;
        irq0_n  = 1'b1;
        irq1_n  = 1'b1;
        cnt_pin = 1'b1;
    end

    // source holds the low level until told to let go
    always @(negedge clk) begin
        irq0_n <= ~irq_low[0];
        irq1_n <= ~irq_low[1];
    end

    // each pulse three cycles high then three low
    always @(negedge clk) begin
        if (left > 0) begin
            left    <= left - 1;
            cnt_pin <= ((left - 1) % 6) >= 3;
        end else if (go) begin
            left <= 6 * pulses;
        end else begin
            cnt_pin <= 1'b1;
        end
    end

    assign busy = (left != 0);
endmodule : dtc_pin_model

// File: verif/tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
    begin \
        check_count++; \
        if ((got) !== (ex)) begin \
            failures++; \
            $display("unexpected %s exp %h got %h", nm, ex, got); \
        end \
    end
module tb;
    import dtc_pkg::*;
    logic        clk, rst_n, sfr_wr, sfr_rd, sfr_rvalid, go, t1;
    logic  [7:0] sfr_addr, sfr_wdata, sfr_rdata, pulses, v, ev;
    logic        of0, of1, rq0, rq1, irq0_n, irq1_n, cnt_pin, busy;
    logic  [3:0] acks, flg;
    logic  [1:0] irq_low, m;
    logic [31:0] seed;
    int          failures, check_count, i, n, b;
    logic  [7:0] exp_q[$];

    assign flg = {of1, of0, rq1, rq0};

    dtc_timer_ctl u_dut (
        .CLK(clk), .RST_N(rst_n), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
        .SFR_WDATA(sfr_wdata), .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata),
        .SFR_RVALID(sfr_rvalid), .ACK_T0(acks[2]), .ACK_T1(acks[3]),
        .ACK_X0(acks[0]), .ACK_X1(acks[1]), .EXT_IRQ0_PIN_N(irq0_n),
        .EXT_IRQ1_PIN_N(irq1_n), .T0_COUNT_PIN(cnt_pin),
        .T1_COUNT_PIN(cnt_pin), .TIMER0_OVERFLOW_FLAG(of0),
        .TIMER1_OVERFLOW_FLAG(of1), .EXT_IRQ0_REQUEST_FLAG(rq0),
        .EXT_IRQ1_REQUEST_FLAG(rq1));

    dtc_pin_model u_pins (
        .clk(clk), .irq_low(irq_low), .pulses(pulses), .go(go),
        .irq0_n(irq0_n), .irq1_n(irq1_n), .cnt_pin(cnt_pin),
        .busy(busy));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic end_of_test();
        if (exp_q.size() != 0) failures++;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        exp_q.push_back(d);
        @(negedge clk);
        sfr_rd = 1'b0;
    endtask : rd

    task automatic ack(input logic [3:0] a);
        @(negedge clk);
        acks = a;
        @(negedge clk);
        acks = 4'h0;
    endtask : ack

    task automatic wait_bit(input int k, input logic val);
        int c;
        c = 0;
        while (flg[k] !== val) begin
            @(negedge clk);
            c++;
            if (c > 60) begin
                failures++;
                $display("unexpected flag%0d exp %b got %b", k, val, flg[k]);
                end_of_test();
            end
        end
        check_count++;
    endtask : wait_bit

    // read results checked in order of request
    always @(negedge clk) begin
        if (sfr_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("unexpected read data exp none got %h", sfr_rdata);
            end else begin
                ev = exp_q.pop_front();
                `CHK("read data", ev, sfr_rdata)
            end
        end
    end

    initial begin
        {rst_n, sfr_wr, sfr_rd, go, acks, irq_low} = '0;
        {sfr_addr, sfr_wdata, pulses} = '0;
        seed = 32'h6b63bf13;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        for (i = 0; i < 6; i++) rd(ADDR_TCTL + i[2:0], 8'h00);
        rd(8'h90, 8'h00);
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = seed[7:0];
            wr(ADDR_T0LO + i[1:0], v);
            rd(ADDR_T0LO + i[1:0], v);
        end
        wr(ADDR_TCTL, 8'ha0);
        `CHK("soft set flags", 4'hc, flg)
        rd(ADDR_TCTL, 8'ha0);
        wr(ADDR_TCTL, 8'h00);
        `CHK("soft clear flags", 4'h0, flg)
        for (i = 0; i < 8; i++) begin
            t1 = i[2];
            m  = i[1:0];
            b  = (t1 || m == 2'h3) ? 3 : 2;
            wr(ADDR_MODE, t1 ? {2'h0, m, 4'h0} : {6'h0, m});
            wr(t1 ? ADDR_T1LO : ADDR_T0LO, 8'hfe);
            wr(t1 ? ADDR_T1HI : ADDR_T0HI, (b == 3 && !t1) ? 8'hfe : 8'hff);
            repeat (6) @(negedge clk);
            `CHK("idle flags", 4'h0, flg)
            wr(ADDR_TCTL, b == 3 ? 8'h40 : 8'h10);
            if (t1 && m == 2'h3) begin
                repeat (20) @(negedge clk);
                `CHK("held timer1 flags", 4'h0, flg)
            end else begin
                wait_bit(b, 1'b1);
                wr(ADDR_TCTL, b == 3 ? 8'h80 : 8'h20);
                if (m == 2'h2) rd(t1 ? ADDR_T1HI : ADDR_T0HI, 8'hff);
                ack(4'h1 << b);
                `CHK("acked flags", 4'h0, flg)
            end
            wr(ADDR_TCTL, 8'h00);
        end
        wr(ADDR_MODE, 8'h99);
        for (i = 0; i < 4; i++) wr(ADDR_T0LO + i[1:0], i[1] ? 8'hff : 8'hfe);
        irq_low <= 2'b11;
        repeat (8) @(negedge clk);
        wr(ADDR_TCTL, 8'h50);
        repeat (12) @(negedge clk);
        `CHK("gated timer flags", 2'h0, flg[3:2])
        irq_low <= 2'b00;
        wait_bit(2, 1'b1);
        wait_bit(3, 1'b1);
        wr(ADDR_TCTL, 8'h00);
        wr(ADDR_MODE, 8'h55);
        for (i = 0; i < 4; i++) wr(ADDR_T0LO + i[1:0], 8'h00);
        wr(ADDR_TCTL, 8'h50);
        pulses <= 8'h05;
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        for (n = 0; n < 3 || (busy === 1'b1 && n < 100); n++) @(negedge clk);
        `CHK("pulse train done", 1'b0, busy)
        repeat (8) @(negedge clk);
        wr(ADDR_TCTL, 8'h00);
        rd(ADDR_T0LO, 8'h05);
        rd(ADDR_T1LO, 8'h05);
        for (i = 0; i < 4; i++) begin
            b  = i % 2;
            t1 = i[1];
            wr(ADDR_TCTL, t1 ? (b ? 8'h04 : 8'h01) : 8'h00);
            irq_low <= 2'b01 << b;
            wait_bit(b, 1'b1);
            ack(4'h1 << b);
            `CHK("request flag after ack", !t1, flg[b])
            `CHK("timer flags", 2'h0, flg[3:2])
            irq_low <= 2'b00;
            wait_bit(b, 1'b0);
        end
        repeat (4) @(negedge clk);
        end_of_test();
    end
endmodule : tb
